/* rtl/scbc_map.svh */
// Offsets, field positions, reset values and instruction codes of the clock control block
// Overview of operation
// - Only the first oscillator type selection after reset counts; later ones are ignored.
// - A type selection picks the oscillator circuit only; no start, no source change.
// - Without any type selection the main clock stays unusable; on-chip oscillator only.
// - A source that is not oscillating can never become the system clock.
// - The oscillator currently selected as system clock source cannot be stopped.
// - In back-up with main oscillator stopped, the internal main clock node is held high.
// - From reset the main clock node stays high until ceramic chosen and main enabled.
// - Back-up is entered only when the entry instruction directly follows arming.
// - An entry instruction without arming directly before it does not enter back-up.
// - Main oscillator stop bit: 0 enables oscillation, 1 stops it.
// - Source bit: 0 selects main oscillator, 1 selects the on-chip oscillator.
// - Write-only on-chip oscillator stop bit: 0 enables, 1 stops.
// - Two-bit mode field divides the selected source by 1, 2, 4 or 8.
`ifndef SCBC_MAP_SVH
`define SCBC_MAP_SVH

`define SCBC_ADDR_W 12
`define SCBC_OFS_MODE 12'h000
`define SCBC_OFS_RING 12'h004
`define SCBC_OFS_INSTR 12'h008
`define SCBC_OFS_STATUS 12'h00c

`define SCBC_MODE_SRC 0
`define SCBC_MODE_MSTOP 1
`define SCBC_MODE_DIV_LO 2
`define SCBC_MODE_DIV_HI 3
`define SCBC_MODE_RST 4'hf
`define SCBC_RING_RST 1'h0

`define SCBC_INS_NOP 4'h0
`define SCBC_INS_CERAMIC 4'h1
`define SCBC_INS_RC 4'h2
`define SCBC_INS_CRYSTAL 4'h3
`define SCBC_INS_ARM 4'h4
`define SCBC_INS_ENTER 4'h5
`define SCBC_INS_IRQ_OFF 4'h6

`endif

/* rtl/scbc_pkg.sv */
// Types of the clock control block
package scbc_pkg;
  typedef enum logic [1:0] {OSC_NONE, OSC_CERAMIC, OSC_RC, OSC_CRYSTAL} scbc_osc_e;

  typedef struct packed {
    logic [3:0] mode;
    logic ring_stop;
    scbc_osc_e osc_type;
    logic type_locked;
    logic armed;
    logic backup;
    logic released;
    logic xin_node;
    logic ring_prev;
    logic sys_tick;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scbc_state_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } scbc_div_s;
endpackage : scbc_pkg

/* rtl/scbc_div.sv */
// Source tick divider: passes one tick in 1, 2, 4 or 8
`timescale 1ns/100ps
module scbc_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  input wire logic [1:0] div_sel,
  output logic tick_out
);
  scbc_pkg::scbc_div_s st;
  scbc_pkg::scbc_div_s next_st;
  logic [2:0] mask;

  always_comb begin
    mask = 3'h0;
    unique case (div_sel)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
    endcase
    next_st = st;
    next_st.tick = 1'b0;
    if (tick_in) begin
      next_st.cnt = (st.cnt & mask) == mask ? 3'h0 : 3'(st.cnt + 3'h1);
      next_st.tick = (st.cnt & mask) == mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;

  property p_div8;
    @(posedge pclk) disable iff (!presetn)
      tick_out && div_sel == 2'h3 ##1 (div_sel == 2'h3)[*8] |-> st.cnt == 3'h0 || !tick_out;
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 count out of step");
  c_div8: cover property (@(posedge pclk) disable iff (!presetn) tick_out && div_sel == 2'h3);
endmodule : scbc_div

/* rtl/scbc_top.sv */
// Clock source control, type lock and back-up entry with APB register access
`timescale 1ns/100ps
`include "scbc_map.svh"
module scbc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xin_pad,
  input wire logic ring_osc_clk,
  input wire logic wake_in,
  output logic xin_node,
  output logic sys_tick,
  output logic main_osc_on,
  output logic ring_osc_on,
  output logic backup_state,
  output logic [1:0] osc_type
);
  scbc_pkg::scbc_state_s st;
  scbc_pkg::scbc_state_s next_st;
  logic [`SCBC_ADDR_W-1:0] addr;
  logic setup;
  logic wr;
  logic mode_wr;
  logic ring_wr;
  logic ins_wr;
  logic [3:0] code;
  logic mapped;
  logic [31:0] rd_word;
  logic main_tick;
  logic ring_tick;
  logic div_out;
  logic req_src;
  logic req_mstop;
  logic req_rstop;

  assign addr = paddr[`SCBC_ADDR_W-1:0];
  assign setup = psel && !penable;
  // Unmapped writes answer with an error and must not alias onto a register
  assign wr = psel && penable && st.pready && pwrite && mapped;
  assign mode_wr = wr && addr == `SCBC_OFS_MODE;
  assign ring_wr = wr && addr == `SCBC_OFS_RING;
  assign ins_wr = wr && addr == `SCBC_OFS_INSTR;
  assign code = pwdata[3:0];
  assign mapped = paddr[31:`SCBC_ADDR_W] == '0 &&
                  (addr == `SCBC_OFS_MODE || addr == `SCBC_OFS_RING ||
                   addr == `SCBC_OFS_INSTR || addr == `SCBC_OFS_STATUS);

  // Edge of each running source is one source tick
  assign main_tick = !st.mode[`SCBC_MODE_MSTOP] && xin_pad && !st.xin_node;
  assign ring_tick = !st.ring_stop && ring_osc_clk && !st.ring_prev;

  scbc_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(st.mode[`SCBC_MODE_SRC] ? ring_tick : main_tick),
    .div_sel(st.mode[`SCBC_MODE_DIV_HI:`SCBC_MODE_DIV_LO]),
    .tick_out(div_out)
  );

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (addr)
      `SCBC_OFS_MODE: rd_word = {28'h000_0000, st.mode};
      `SCBC_OFS_STATUS: rd_word = {24'h00_0000, st.released, st.backup, st.armed, st.type_locked,
                                   st.osc_type, !st.ring_stop, !st.mode[`SCBC_MODE_MSTOP]};
      default: rd_word = 32'h0000_0000; // Ring stop bit is write-only
    endcase
  end

  always_comb begin
    next_st = st;
    req_src = pwdata[`SCBC_MODE_SRC];
    req_mstop = pwdata[`SCBC_MODE_MSTOP] || !st.type_locked;
    req_rstop = pwdata[0];
    next_st.pready = setup;
    next_st.pslverr = setup && !mapped;
    if (setup) begin
      next_st.prdata = mapped ? rd_word : 32'h0000_0000;
    end
    if (mode_wr) begin
      next_st.mode[`SCBC_MODE_DIV_HI:`SCBC_MODE_DIV_LO] = pwdata[`SCBC_MODE_DIV_HI:`SCBC_MODE_DIV_LO];
      // Refuse a source that would not be oscillating after the write
      if ((!req_src && req_mstop) || (req_src && st.ring_stop)) begin
        req_src = st.mode[`SCBC_MODE_SRC];
      end
      next_st.mode[`SCBC_MODE_SRC] = req_src;
      if (!req_src && req_mstop) begin
        req_mstop = st.mode[`SCBC_MODE_MSTOP];
      end
      next_st.mode[`SCBC_MODE_MSTOP] = req_mstop;
    end
    if (ring_wr) begin
      next_st.ring_stop = (req_rstop && st.mode[`SCBC_MODE_SRC]) ? st.ring_stop : req_rstop;
    end
    if (ins_wr) begin
      // Any executed instruction other than arming breaks the arming
      next_st.armed = code == `SCBC_INS_ARM;
      if (code == `SCBC_INS_ENTER && st.armed) begin
        next_st.backup = 1'b1;
      end
      if (!st.type_locked) begin
        unique case (code)
          `SCBC_INS_CERAMIC: next_st.osc_type = scbc_pkg::OSC_CERAMIC;
          `SCBC_INS_RC: next_st.osc_type = scbc_pkg::OSC_RC;
          `SCBC_INS_CRYSTAL: next_st.osc_type = scbc_pkg::OSC_CRYSTAL;
          default: next_st.osc_type = st.osc_type;
        endcase
        next_st.type_locked = code == `SCBC_INS_CERAMIC || code == `SCBC_INS_RC ||
                              code == `SCBC_INS_CRYSTAL;
      end
    end
    if (st.backup && wake_in) begin
      next_st.backup = 1'b0;
    end
    // Release needs a lock and a cleared stop bit; only ceramic opens the pad
    if (st.osc_type == scbc_pkg::OSC_CERAMIC && !st.mode[`SCBC_MODE_MSTOP]) begin
      next_st.released = 1'b1;
    end
    next_st.xin_node = ((st.backup && st.mode[`SCBC_MODE_MSTOP]) || !st.released) ? 1'b1 : xin_pad;
    next_st.ring_prev = ring_osc_clk;
    // Back-up freezes the system clock
    next_st.sys_tick = div_out && !st.backup;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.mode <= `SCBC_MODE_RST;
      st.ring_stop <= `SCBC_RING_RST;
      st.osc_type <= scbc_pkg::OSC_NONE;
      st.xin_node <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign xin_node = st.xin_node;
  assign sys_tick = st.sys_tick;
  assign main_osc_on = !st.mode[`SCBC_MODE_MSTOP];
  assign ring_osc_on = !st.ring_stop;
  assign backup_state = st.backup;
  assign osc_type = st.osc_type;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_type_once;
    st.type_locked |=> $stable(st.osc_type) && st.type_locked;
  endproperty
  a_type_once: assert property (p_type_once) else $error("oscillator type changed after lock");

  property p_sel_only;
    ins_wr && code != `SCBC_INS_NOP |=> $stable(st.mode);
  endproperty
  a_sel_only: assert property (p_sel_only) else $error("instruction changed clock mode bits");

  property p_no_type;
    !st.type_locked |-> st.mode[`SCBC_MODE_MSTOP] && st.mode[`SCBC_MODE_SRC];
  endproperty
  a_no_type: assert property (p_no_type) else $error("main clock used without type");

  property p_live_src;
    !(st.mode[`SCBC_MODE_SRC] ? st.ring_stop : st.mode[`SCBC_MODE_MSTOP]);
  endproperty
  a_live_src: assert property (p_live_src) else $error("stopped source selected");

  property p_keep_sel;
    $rose(st.ring_stop) |-> !st.mode[`SCBC_MODE_SRC] && $past(!st.mode[`SCBC_MODE_SRC]);
  endproperty
  a_keep_sel: assert property (p_keep_sel) else $error("selected on-chip oscillator stopped");

  property p_backup_high;
    st.backup && st.mode[`SCBC_MODE_MSTOP] |=> xin_node;
  endproperty
  a_backup_high: assert property (p_backup_high) else $error("main node not held high in back-up");

  property p_reset_high;
    !st.released |=> xin_node;
  endproperty
  a_reset_high: assert property (p_reset_high) else $error("main node released too early");

  property p_enter;
    $rose(st.backup) |-> $past(ins_wr && code == `SCBC_INS_ENTER && st.armed);
  endproperty
  a_enter: assert property (p_enter) else $error("back-up entered without arming");

  property p_no_enter;
    ins_wr && code == `SCBC_INS_ENTER && !st.armed && !st.backup |=> !st.backup;
  endproperty
  a_no_enter: assert property (p_no_enter) else $error("unarmed entry took effect");

  property p_main_sel;
    mode_wr && !pwdata[`SCBC_MODE_SRC] && !pwdata[`SCBC_MODE_MSTOP] && st.type_locked
      |=> !st.mode[`SCBC_MODE_SRC] && !st.mode[`SCBC_MODE_MSTOP];
  endproperty
  a_main_sel: assert property (p_main_sel) else $error("main source not taken");

  c_lock: cover property (ins_wr && code == `SCBC_INS_CERAMIC ##[1:40] !st.mode[`SCBC_MODE_MSTOP]);
  c_backup: cover property ($rose(st.backup));
  c_refused: cover property (mode_wr && !pwdata[`SCBC_MODE_SRC] && st.mode[`SCBC_MODE_MSTOP]);
endmodule : scbc_top

/* test/scbc_xin_model.sv */
// Model of the resonator or external clock source on the main clock input
`timescale 1ns/100ps
module scbc_xin_model (
  input wire logic pclk,
  input wire logic run,
  input wire logic ext,
  input wire logic slow,
  output logic xin_pad
);
  logic ph;
  initial begin
    xin_pad = 1'b0;
    ph = 1'b0;
  end
  // Resonator stands still while stopped; an external source runs regardless
  always @(posedge pclk) begin
    ph <= ~ph;
    if ((run || ext) && (!slow || ph)) begin
      xin_pad <= ~xin_pad;
    end
  end
endmodule : scbc_xin_model

/* test/tb_system_clock_and_backup_control.sv */
// Self-checking bench of the clock control block with a behavioural model
`timescale 1ns/100ps
`include "scbc_map.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_system_clock_and_backup_control;
  logic pclk, presetn, psel, penable, pwrite, xin_pad, ring_osc_clk, wake_in, ext, slow, a, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, xin_node, sys_tick, main_osc_on, ring_osc_on, backup_state;
  logic [1:0] osc_type;
  int err_count, checked, cyc, n, m_mode, m_type, m_ring, m_arm, m_bk, m_rel;

  scbc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xin_pad(xin_pad),
    .ring_osc_clk(ring_osc_clk), .wake_in(wake_in), .xin_node(xin_node), .sys_tick(sys_tick),
    .main_osc_on(main_osc_on), .ring_osc_on(ring_osc_on), .backup_state(backup_state), .osc_type(osc_type));
  scbc_xin_model u_xin (.pclk(pclk), .run(main_osc_on), .ext(ext), .slow(slow), .xin_pad(xin_pad));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic wrap_up();
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // On-chip oscillator stands still while stopped; hang guard beside it
  always @(posedge pclk) begin
    ring_osc_clk <= ring_osc_on ? ~ring_osc_clk : ring_osc_clk;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic apb(input logic w, input logic [31:0] adr, input logic [31:0] dat);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= adr;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr_mode(input int v);
    int s;
    int t;
    s = v & 1;
    t = (v >> 1) & 1;
    if (m_type == 0) t = 1;
    // On-chip refusal looks at the requested source; main and stop refusals see its result
    if (s == 1 && m_ring == 1) s = m_mode & 1;
    if (t == 1 && s == 0) begin
      if ((m_mode & 1) == 0) t = (m_mode >> 1) & 1;
      else s = 1;
    end
    m_mode = (v & 12) | (t << 1) | s;
    if (m_type == 1 && t == 0) m_rel = 1;
    apb(1'b1, `SCBC_OFS_MODE, 32'(v));
  endtask : wr_mode

  task automatic wr_ring(input int v);
    if ((m_mode & 1) == 0 || v == 0) m_ring = v;
    apb(1'b1, `SCBC_OFS_RING, 32'(v));
  endtask : wr_ring

  task automatic instr(input int c);
    if (c >= 1 && c <= 3 && m_type == 0) m_type = c;
    if (c == 5 && m_arm == 1) m_bk = 1;
    m_arm = (c == 4);
    apb(1'b1, `SCBC_OFS_INSTR, {28'($urandom()), 4'(c)});
  endtask : instr

  task automatic chk();
    apb(1'b0, `SCBC_OFS_STATUS, 32'h0);
    `CHK("status", m_rel * 128 + m_bk * 64 + m_arm * 32 + (m_type > 0 ? 16 : 0) + m_type * 4 +
         (1 - m_ring) * 2 + 1 - ((m_mode >> 1) & 1), rd)
    apb(1'b0, `SCBC_OFS_MODE, 32'h0);
    `CHK("mode", m_mode, rd)
    `CHK("osc_type", 2'(m_type), osc_type)
    `CHK("backup", 1'(m_bk), backup_state)
    `CHK("ring_on", 1'(1 - m_ring), ring_osc_on)
  endtask : chk

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    m_mode = 15;
    m_type = 0;
    m_ring = 0;
    m_arm = 0;
    m_bk = 0;
    m_rel = 0;
    @(posedge pclk);
  endtask : do_reset

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ring_osc_clk = 1'b0;
    wake_in = 1'b0;
    ext = 1'b1;
    slow = 1'b0;
    err_count = 0;
    checked = 0;
    cyc = 0;
    void'($urandom(53));
    // External clock on the pad throughout, so a forced node is visible
    for (int k = 3; k >= 1; k--) begin
      do_reset();
      `CHK("node_rst", 1'b1, xin_node)
      chk();
      wr_mode(13);
      instr(k);
      `CHK("main_idle", 1'b0, main_osc_on)
      instr(k % 3 + 1);
      wr_mode(13);
      chk();
      a = xin_node;
      @(posedge pclk);
      `CHK("node_free", k == 1, a !== xin_node)
    end
    wr_ring(1);
    wr_mode(12);
    wr_ring(1);
    wr_mode(13);
    wr_mode(14);
    chk();
    ext <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      slow <= 1'($urandom());
      wr_mode(d << 2);
      repeat (8) @(posedge pclk);
      n = 0;
      repeat (64) begin
        @(posedge pclk);
        n += sys_tick;
      end
      `CHK("ticks", 1'b1, ((slow ? 16 : 32) >> d) - n inside {-1, 0, 1})
    end
    chk();
    wr_ring(0);
    wr_mode(13);
    wr_mode(15);
    ext <= 1'b1;
    instr(6);
    instr(4);
    instr(0);
    instr(5);
    chk();
    instr(4);
    instr(5);
    repeat (8) begin
      @(posedge pclk);
      `CHK("node_hold", 2'b01, {sys_tick, xin_node})
    end
    chk();
    wake_in <= 1'b1;
    @(posedge pclk);
    wake_in <= 1'b0;
    m_bk = 0;
    @(posedge pclk);
    chk();
    apb(1'b1, 32'h10, 32'h0);
    `CHK("slverr", 1'b1, er)
    wrap_up();
  end
endmodule : tb_system_clock_and_backup_control
